/* hdl/rsse_exec.sv */
// execution unit: rotate through carry, subtract, sleep
// Notes on behaviour
// - rotate left: carry into bit0, bit7 out
// - rotate right: carry into bit7, bit0 out
// - dest 0 writes accumulator, 1 writes file
// - rotates touch only carry among flags
// - sleep clears power-down flag
// - sleep sets watchdog expiry flag
// - sleep zeroes watchdog counter and prescaler
// - subtract gives file minus accumulator
// - nibble flag set when low nibbles not above
`timescale 1ns/1ps
module rsse_exec
    import rsse_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    // decoder request
    input wire logic opValid,
    input wire rsse_op_t opCode,
    input wire logic [ADDR_W-1:0] fileAddr,
    input wire logic destSel,
    // operand read from the register file
    input wire logic [DATA_W-1:0] fileData,
    // register file write-back
    output logic fileWrEn_ff,
    output logic [ADDR_W-1:0] fileWrAddr_ff,
    output logic [DATA_W-1:0] fileWrData_ff,
    // accumulator and status flags
    output logic [DATA_W-1:0] acc_ff,
    output logic carryFlag_ff,
    output logic zeroFlag_ff,
    output logic nibble_borrow_flag_ff,
    output logic watchdog_expiry_flag_ff,
    output logic power_down_flag_ff,
    // watchdog stand-in counter and prescaler, busy flag
    output logic [WDOG_W-1:0] watchdog_counter_ff,
    output logic [PRE_W-1:0] watchdogPrescaler_ff,
    output logic busy_ff
);
    // decoded strobes
    wire logic isRol = opValid && (opCode == OP_ROTATE_LEFT_CARRY);
    wire logic isRor = opValid && (opCode == OP_ROTATE_RIGHT_CARRY);
    wire logic isSub = opValid && (opCode == OP_SUBTRACT_ACC_FROM_FILE);
    wire logic isSleep = opValid && (opCode == OP_SLEEP);
    wire logic isRot = isRol || isRor;
    wire logic hasResult = isRot || isSub;

    // rotate results; carry shifts through
    wire logic [DATA_W-1:0] rolRes = {fileData[DATA_W-2:0], carryFlag_ff};
    wire logic [DATA_W-1:0] rorRes = {carryFlag_ff, fileData[DATA_W-1:1]};
    // extra bit of the difference is the borrow; carry is its inverse
    wire logic [DATA_W:0] diff = {1'h0, fileData} - {1'h0, acc_ff};
    // low nibbles alone; the extra bit again is the borrow
    wire logic [NIB_HI+1:0] nibDiff =
        {1'h0, fileData[NIB_HI:0]} - {1'h0, acc_ff[NIB_HI:0]};
    wire logic subCarry = ~diff[DATA_W];
    wire logic subNib = ~nibDiff[NIB_HI+1];
    wire logic [DATA_W-1:0] subRes = diff[DATA_W-1:0];

    // result and next-flag selection
    wire logic [DATA_W-1:0] result = isRol ? rolRes : (isRor ? rorRes : subRes);
    wire logic nxt_carry = isRol ? fileData[DATA_W-1] :
        (isRor ? fileData[0] : subCarry);
    wire logic nxt_zero = (subRes == 8'h00);
    wire logic toFile = hasResult && destSel;
    wire logic toAcc = hasResult && !destSel;

    // state only tracks that an op retired this cycle
    rsse_state_t state_ff; // idle or retiring
    rsse_state_t nxt_state; // from the case below

    // next state; an illegal code falls back to idle
    always_comb begin
        case (state_ff)
            ST_IDLE: nxt_state = opValid ? ST_EXEC : ST_IDLE;
            ST_EXEC: nxt_state = opValid ? ST_EXEC : ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // watchdog stand-in: prescaler ticks every enabled cycle without a sleep and the
    // counter steps when it wraps; kept so a missed clear is visible
    wire logic preWrap = &watchdogPrescaler_ff; // prescaler at top
    wire logic [PRE_W-1:0] nxt_pre = watchdogPrescaler_ff + 8'h01;
    wire logic [WDOG_W-1:0] nxt_wdog = preWrap ?
        watchdog_counter_ff + 8'h01 : watchdog_counter_ff;

    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else if (clkEn) begin
            state_ff <= nxt_state;
        end
    end

    // write-back port; one cycle per op
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fileWrEn_ff <= 1'h0;
            fileWrAddr_ff <= WRADDR_RST;
            fileWrData_ff <= WRDATA_RST;
        end else if (clkEn) begin
            fileWrEn_ff <= toFile;
            fileWrAddr_ff <= fileAddr;
            fileWrData_ff <= result;
        end
    end

    // accumulator
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_ff <= ACC_RST;
        end else if (clkEn && toAcc) begin
            acc_ff <= result;
        end
    end

    // arithmetic flags; rotates leave zero and nibble alone
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            carryFlag_ff <= CARRY_RST;
            zeroFlag_ff <= ZERO_RST;
            nibble_borrow_flag_ff <= NIB_RST;
        end else if (clkEn && hasResult) begin
            carryFlag_ff <= nxt_carry;
            if (isSub) begin
                zeroFlag_ff <= nxt_zero;
                nibble_borrow_flag_ff <= subNib;
            end // rotate
        end
    end

    // sleep effects on power status and watchdog; the stand-in
    // steps on every enabled cycle, sleep wins over the step
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            watchdog_expiry_flag_ff <= EXPIRY_RST;
            power_down_flag_ff <= PDOWN_RST;
            watchdog_counter_ff <= WDOG_CLEAR;
            watchdogPrescaler_ff <= PRE_CLEAR;
        end else if (clkEn && isSleep) begin
            power_down_flag_ff <= 1'h0;
            watchdog_expiry_flag_ff <= 1'h1;
            watchdog_counter_ff <= WDOG_CLEAR;
            watchdogPrescaler_ff <= PRE_CLEAR;
        end else if (clkEn) begin
            watchdog_counter_ff <= nxt_wdog; // stand-in tick
            watchdogPrescaler_ff <= nxt_pre;
        end
    end

    // busy mirrors the retiring-op state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_ff <= BUSY_RST;
        end else if (clkEn) begin
            busy_ff <= (nxt_state == ST_EXEC);
        end
    end

    // checks; each looks one cycle after an enabled edge, chk_frozen_state after a disabled one
    chk_rol_result: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && isRol && destSel |=> fileWrEn_ff &&
        fileWrData_ff == {$past(fileData[6:0]), $past(carryFlag_ff)} &&
        carryFlag_ff == $past(fileData[7]))
        else $error("rotate left wrong");
    chk_rol_acc: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && isRol && !destSel |=> !fileWrEn_ff &&
        acc_ff == {$past(fileData[6:0]), $past(carryFlag_ff)} &&
        carryFlag_ff == $past(fileData[7]))
        else $error("rotate left to accumulator wrong");
    chk_ror_result: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && isRor && !destSel |=> !fileWrEn_ff &&
        acc_ff == {$past(carryFlag_ff), $past(fileData[7:1])} &&
        carryFlag_ff == $past(fileData[0]))
        else $error("rotate right wrong");
    chk_ror_file: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && isRor && destSel |=> fileWrEn_ff && $stable(acc_ff) &&
        fileWrData_ff == {$past(carryFlag_ff), $past(fileData[7:1])} &&
        carryFlag_ff == $past(fileData[0]))
        else $error("rotate right to file wrong");
    chk_dest_file: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && isSub && destSel |=> fileWrEn_ff && $stable(acc_ff))
        else $error("file destination wrong");
    chk_refused_op: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && opValid && !hasResult && !isSleep |=> !fileWrEn_ff &&
        $stable(acc_ff) && $stable(carryFlag_ff) &&
        $stable(power_down_flag_ff))
        else $error("unknown op changed state");
    chk_rot_flags: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && isRot |=> $stable(zeroFlag_ff) &&
        $stable(nibble_borrow_flag_ff))
        else $error("rotate touched other flags");
    chk_sleep_pdown: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && isSleep |=> !power_down_flag_ff)
        else $error("power-down not cleared");
    chk_sleep_expiry: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && isSleep |=> watchdog_expiry_flag_ff)
        else $error("expiry not set");
    chk_sleep_watchdog: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && isSleep |=> watchdog_counter_ff == 8'h00 &&
        watchdogPrescaler_ff == 8'h00)
        else $error("watchdog not cleared");
    chk_wdog_tick: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && !isSleep |=>
        {watchdog_counter_ff, watchdogPrescaler_ff} ==
        16'({$past(watchdog_counter_ff), $past(watchdogPrescaler_ff)} +
        16'h0001))
        else $error("watchdog stand-in did not step");
    chk_sub_diff: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && isSub && !destSel |=>
        acc_ff == 8'($past(fileData) - $past(acc_ff)))
        else $error("difference wrong");
    chk_sub_carry: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && isSub |=>
        carryFlag_ff == ($past(acc_ff) <= $past(fileData)))
        else $error("carry wrong");
    chk_sub_nibble: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && isSub |=> nibble_borrow_flag_ff ==
        ($past(acc_ff[3:0]) <= $past(fileData[3:0])))
        else $error("nibble flag wrong");
    chk_sub_zero: assert property (
        @(posedge ref_clk) disable iff (rst)
        clkEn && isSub |=> zeroFlag_ff ==
        ($past(fileData) == $past(acc_ff)))
        else $error("zero flag wrong");
    chk_frozen_state: assert property (
        @(posedge ref_clk) disable iff (rst)
        !clkEn |=> $stable(acc_ff) && $stable(fileWrEn_ff) &&
        $stable(carryFlag_ff) && $stable(busy_ff) &&
        $stable(watchdogPrescaler_ff))
        else $error("state moved with enable low");
endmodule : rsse_exec

/* hdl/rsse_pkg.sv */
// package: opcodes, states, widths, reset values for the exec block
package rsse_pkg;
    // operation select from the decoder
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ROTATE_LEFT_CARRY = 4'h1,
        OP_ROTATE_RIGHT_CARRY = 4'h2,
        OP_SUBTRACT_ACC_FROM_FILE = 4'h3,
        OP_SLEEP = 4'h4
    } rsse_op_t;
    // execution state, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_EXEC = 2'h2
    } rsse_state_t;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int WDOG_W = 8;
    localparam int PRE_W = 8;
    localparam int NIB_HI = 3;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] WDOG_CLEAR = 8'h00;
    localparam logic [7:0] PRE_CLEAR = 8'h00;
    localparam logic CARRY_RST = 1'h0;
    localparam logic ZERO_RST = 1'h0;
    localparam logic NIB_RST = 1'h0;
    localparam logic EXPIRY_RST = 1'h1;
    localparam logic PDOWN_RST = 1'h1;
    localparam logic [6:0] WRADDR_RST = 7'h00;
    localparam logic [7:0] WRDATA_RST = 8'h00;
    localparam logic BUSY_RST = 1'h0;
endpackage : rsse_pkg

/* tb/rotate_subtract_sleep_exec_test.sv */
// self-checking bench for the rotate, subtract and sleep exec unit
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module rotate_subtract_sleep_exec_test;
    import rsse_pkg::*;
    // stimulus
    logic ref_clk = 0, rst = 1, clkEn = 1, opValid = 0, destSel = 0;
    rsse_op_t opCode = OP_NONE;
    logic [6:0] fileAddr = 7'h00;
    // observed
    logic [7:0] fileData, wrData, acc, wdog, pre;
    logic [6:0] wrAddr;
    logic wrEn, carry, zero, nib, expiry, pdown, busy;
    // expected state, starts at reset values
    logic [7:0] eAcc = 8'h00;
    logic eC = 0, eZ = 0, eN = 0, eExp = 1, eDown = 1;
    logic [15:0] wdTicks = 16'h0000; // enabled ticks since reset or sleep
    int failures = 0, n_checks = 0, cyc = 0;
    rsse_exec i_dut (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
        .opValid(opValid), .opCode(opCode), .fileAddr(fileAddr),
        .destSel(destSel), .fileData(fileData), .fileWrEn_ff(wrEn),
        .fileWrAddr_ff(wrAddr), .fileWrData_ff(wrData), .acc_ff(acc),
        .carryFlag_ff(carry), .zeroFlag_ff(zero),
        .nibble_borrow_flag_ff(nib), .watchdog_expiry_flag_ff(expiry),
        .power_down_flag_ff(pdown), .watchdog_counter_ff(wdog),
        .watchdogPrescaler_ff(pre), .busy_ff(busy));
    rsse_regfile_model i_mem (.ref_clk(ref_clk), .fileAddr(fileAddr),
        .fileData(fileData), .fileWrEn(wrEn), .wrAddr(wrAddr),
        .wrData(wrData));
    // 40 MHz clock
    initial forever #12.5 ref_clk = ~ref_clk;
    // watchdog view: one tick per enabled edge, sleep restarts it
    always @(posedge ref_clk) begin
        if (rst) wdTicks <= 16'h0000;
        else if (clkEn) wdTicks <= (opValid && opCode == OP_SLEEP) ?
            16'h0000 : wdTicks + 16'h0001;
    end
    // expected subtract: {difference, carry, nibble, zero}
    function automatic logic [10:0] exp_sub(input logic [7:0] f,
                                            input logic [7:0] w);
        logic [7:0] d;
        d = f - w;
        return {d, w <= f, w[3:0] <= f[3:0], d == 8'h00};
    endfunction : exp_sub
    // verdict and end of run
    task final_report;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    // hang guard: a few hundred ops need well under 5000 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            final_report;
        end
    end
    // one op pulse; en low means the edge is not enabled
    task automatic do_op(input logic [3:0] op, input logic [6:0] a,
                         input logic d, input logic en);
        logic [7:0] f, r;
        logic wr;
        @(posedge ref_clk);
        opValid <= 1;
        opCode <= rsse_op_t'(op);
        fileAddr <= a;
        destSel <= d;
        clkEn <= en;
        #1 f = fileData;
        r = eAcc;
        wr = 0;
        if (en) case (op)
            4'h1: begin r = {f[6:0], eC}; eC = f[7]; wr = 1; end
            4'h2: begin r = {eC, f[7:1]}; eC = f[0]; wr = 1; end
            4'h3: begin
                {r, eC, eN, eZ} = exp_sub(f, eAcc);
                wr = 1;
            end
            4'h4: begin eExp = 1; eDown = 0; end
            default: ; // unknown codes change nothing
        endcase
        if (wr && !d) eAcc = r;
        @(posedge ref_clk);
        opValid <= 0;
        clkEn <= 1;
        #1 `CHK(wrEn, wr && d)
        if (wr && d) `CHK({wrAddr, wrData}, {a, r})
        `CHK({acc, carry, zero, nib}, {eAcc, eC, eZ, eN})
        `CHK({expiry, pdown}, {eExp, eDown})
        `CHK({wdog, pre}, wdTicks)
        `CHK(busy, en)
    endtask : do_op
    // corners first, then random traffic
    initial begin
        void'($urandom(98224));
        repeat (3) @(posedge ref_clk);
        rst <= 0;
        do_op(4'h3, 7'h05, 0, 1); // acc takes e6
        do_op(4'h3, 7'h05, 0, 1); // equal operands give zero
        do_op(4'h2, 7'h01, 0, 1); // clears carry
        do_op(4'h1, 7'h05, 0, 1); // e6 with carry 0 gives cc
        do_op(4'h3, 7'h01, 1, 1); // acc above file, both flags low
        do_op(4'h4, 7'h00, 0, 1);
        do_op(4'h2, 7'h7f, 1, 1); // top address
        repeat (300) do_op(4'($urandom % 8), 7'($urandom), 1'($urandom),
                           ($urandom % 8) != 0);
        final_report;
    end
endmodule : rotate_subtract_sleep_exec_test

/* tb/rsse_regfile_model.sv */
// register file model: combinational read, registered strobed write
`timescale 1ns/1ps
module rsse_regfile_model (
    // clock
    input wire logic ref_clk,
    // read side
    input wire logic [6:0] fileAddr,
    output logic [7:0] fileData,
    // write-back side
    input wire logic fileWrEn,
    input wire logic [6:0] wrAddr,
    input wire logic [7:0] wrData
);
    logic [7:0] mem [128]; // all 128 places, no reset like real ram
    // fixed fill so the bench can predict it; mem[5] is 8'he6
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 45);
    assign fileData = mem[fileAddr];
    // write lands at the edge that ends the strobe cycle
    always @(posedge ref_clk) if (fileWrEn) mem[wrAddr] <= wrData;
endmodule : rsse_regfile_model
